// ===== acq_control.sv
// trigger-flow sequencer, storage qualifier and capture control with AXI4-Lite registers
//
// Notes on behaviour
// - goto moves sequencer to named state
// - storage actions act only when state-qualified
// - storage actions never with segmented buffer
// - qualified: nothing stored before storage-on
// - after trigger store post-fill, then finish
// - storage off after trigger pauses capture
// - stop ends paused capture as triggered
// - counter, flags, state readable live
// - evaluate everything every sample clock
// - split: 12/88, 50/50, 88/12
// - split applies per segment too
// - separate runtime and power-up positions
// - post-fill sets samples for buffer/segment
// - trigger index = depth minus post-fill
// - segment without post-fill uses split
// - power-up arming right after configuration
// - counter increment, decrement, reset to initial
// - flag set to one or cleared
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module acq_control #(
  parameter int PW         = 8,
  parameter int DEPTH      = 64,
  parameter int NSEG       = 4,
  parameter bit POWERUP_EN = 1'b0
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // write address and data
  input  wire logic [7:0]    awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  // write response
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // read address and data
  input  wire logic [7:0]    araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // probed design signals
  input  wire logic [PW-1:0] probe
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(NSEG);
  localparam int CW = 8;
  localparam logic [AW:0] FULL_D = (AW+1)'(DEPTH);
  localparam logic [AW:0] SEG_D  = (AW+1)'(DEPTH / NSEG);

  logic [31:0]          ctrl_r;
  logic [31:0]          pfill_r;
  logic [31:0]          raddr_r;
  logic [31:0]          prog_r [4];
  flow_pkg::acq_t       acq_r;
  logic [1:0]           seq_r;
  logic [CW-1:0]        cnt_r;
  logic [1:0]           flag_r;
  logic                 we_r;
  logic [AW-1:0]        off_r;
  logic [SW-1:0]        seg_r;
  logic [AW:0]          post_r;
  logic [AW:0]          spost_r;
  logic                 sact_r;
  logic                 trig_r;
  logic [AW:0]          tidx_r;
  logic [1:0]           pos_r;
  logic                 arm_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 rvalid_r;
  logic [1:0]           rresp_r;
  logic [31:0]          rdata_r;
  logic [PW-1:0]        mem_q;
  logic                 f_go;
  logic [1:0]           f_go_st;
  logic                 f_son;
  logic                 f_soff;
  logic                 f_trig;
  logic                 f_segt;
  logic [1:0]           f_cop;
  logic [1:0]           f_fop;
  logic                 f_fsel;
  logic                 f_upf;

  // control fields and derived conditions
  logic          qual_eff;
  logic          seg_en;
  logic          running;
  logic          mem_we;
  logic          wr_go;
  logic          rd_go;
  logic          cmd_start;
  logic          cmd_stop;
  logic          start_go;
  logic [1:0]    start_pos;
  logic [AW:0]   cur_depth;
  logic [AW:0]   tpost;
  logic [AW:0]   spost_ld;
  logic [AW-1:0] waddr_m;

  assign seg_en    = ctrl_r[flow_pkg::CTRL_SEG];
  // storage actions gated by qualifier mode
  // and never with a segmented buffer
  assign qual_eff  = ctrl_r[flow_pkg::CTRL_QUAL] & ~seg_en;
  assign running   = (acq_r == flow_pkg::ACQ_RUN) || (acq_r == flow_pkg::ACQ_POST);
  // qualified capture writes only behind the enable
  assign mem_we    = running && (qual_eff ? we_r : 1'b1);
  // depth of one segment or the whole buffer
  assign cur_depth = seg_en ? SEG_D : FULL_D;
  // explicit post-fill, else the split setting
  assign tpost     = f_upf ? pfill_r[AW:0]
                           : (AW+1)'(flow_pkg::post_default(pos_r, 16'(cur_depth)));
  // segment end without a count falls back to the split
  assign spost_ld  = f_upf ? pfill_r[AW:0]
                           : (AW+1)'(flow_pkg::post_default(pos_r, 16'(SEG_D)));
  assign waddr_m   = seg_en ? AW'({seg_r, off_r[AW-SW-1:0]}) : off_r;

  // bus handshakes: address and data are taken together
  assign wr_go     = awvalid && wvalid && !bvalid_r;
  assign awready   = wr_go;
  assign wready    = wr_go;
  assign rd_go     = arvalid && !rvalid_r;
  assign arready   = !rvalid_r;
  assign bvalid    = bvalid_r;
  assign bresp     = bresp_r;
  assign rvalid    = rvalid_r;
  assign rresp     = rresp_r;
  assign rdata     = rdata_r;

  assign cmd_start = wr_go && (awaddr == flow_pkg::A_CMD) && wstrb[0]
                     && wdata[flow_pkg::CMD_START];
  assign cmd_stop  = wr_go && (awaddr == flow_pkg::A_CMD) && wstrb[0]
                     && wdata[flow_pkg::CMD_STOP];
  // power-up arming one cycle after reset release
  assign start_go  = (cmd_start && !running) || (arm_r && POWERUP_EN);
  // runtime and power-up positions kept apart
  assign start_pos = (arm_r && POWERUP_EN) ? ctrl_r[flow_pkg::CTRL_PPWR +: 2]
                                           : ctrl_r[flow_pkg::CTRL_PRUN +: 2];

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= flow_pkg::A_LAST);
  endfunction

  // entry decode for the current state
  flow_step #(.PW(PW), .CW(CW)) u_step (
    .entry (prog_r[seq_r]),
    .probe (probe),
    .count (cnt_r),
    .go    (f_go),
    .go_st (f_go_st),
    .son   (f_son),
    .soff  (f_soff),
    .trig  (f_trig),
    .segt  (f_segt),
    .cop   (f_cop),
    .fop   (f_fop),
    .fsel  (f_fsel),
    .upf   (f_upf)
  );

  // acquisition buffer
  capture_mem #(.W(PW), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk   (aclk),
    .we    (mem_we),
    .waddr (waddr_m),
    .wdata (probe),
    .raddr (raddr_r[AW-1:0]),
    .rdata (mem_q)
  );

  // software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r  <= flow_pkg::CTRL_RST;
      pfill_r <= flow_pkg::WORD_RST;
      raddr_r <= flow_pkg::WORD_RST;
      for (int i = 0; i < 4; i++) begin
        prog_r[i] <= flow_pkg::WORD_RST;
      end
    end else if (wr_go) begin
      if (awaddr == flow_pkg::A_CTRL) begin
        ctrl_r <= flow_pkg::merge(ctrl_r, wdata, wstrb);
      end
      if (awaddr == flow_pkg::A_PFILL) begin
        pfill_r <= flow_pkg::merge(pfill_r, wdata, wstrb);
      end
      if (awaddr == flow_pkg::A_RADDR) begin
        raddr_r <= flow_pkg::merge(raddr_r, wdata, wstrb);
      end
      for (int i = 0; i < 4; i++) begin
        if (awaddr == flow_pkg::A_PROG + 8'(4 * i)) begin
          prog_r[i] <= flow_pkg::merge(prog_r[i], wdata, wstrb);
        end
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= flow_pkg::RESP_OK;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(awaddr) ? flow_pkg::RESP_OK : flow_pkg::RESP_ERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // live readback of state, counter and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= flow_pkg::RESP_OK;
      rdata_r  <= flow_pkg::WORD_RST;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= mapped(araddr) ? flow_pkg::RESP_OK : flow_pkg::RESP_ERR;
      rdata_r  <= 32'h0000_0000;
      unique case (araddr)
        flow_pkg::A_CTRL:  rdata_r <= ctrl_r;
        flow_pkg::A_STAT:  begin
          rdata_r[flow_pkg::S_ACQ +: 2]  <= acq_r;
          rdata_r[flow_pkg::S_TRIG]      <= trig_r;
          rdata_r[flow_pkg::S_PAUSE]     <= (acq_r == flow_pkg::ACQ_POST) && !mem_we;
          rdata_r[flow_pkg::S_WE]        <= we_r;
          rdata_r[flow_pkg::S_SEQ +: 2]  <= seq_r;
          rdata_r[flow_pkg::S_SEGN +: 8] <= 8'(seg_r);
        end
        flow_pkg::A_PFILL: rdata_r <= pfill_r;
        flow_pkg::A_CNT:   begin
          rdata_r[flow_pkg::F_CNT +: CW] <= cnt_r;
          rdata_r[flow_pkg::F_FLAG +: 2] <= flag_r;
        end
        flow_pkg::A_TIDX:  rdata_r <= 32'(tidx_r);
        flow_pkg::A_RADDR: rdata_r <= raddr_r;
        flow_pkg::A_RDATA: rdata_r <= 32'(mem_q);
        flow_pkg::A_PROG:  rdata_r <= prog_r[0];
        8'h24:             rdata_r <= prog_r[1];
        8'h28:             rdata_r <= prog_r[2];
        flow_pkg::A_LAST:  rdata_r <= prog_r[3];
        default:           rdata_r <= 32'h0000_0000;
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // power-up arm strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_r <= 1'b1;
    end else begin
      arm_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start_go) begin
      seq_r <= 2'b00;
    end else if (running && f_go) begin
      seq_r <= f_go_st;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start_go) begin
      cnt_r <= flow_pkg::CNT_INIT;
    end else if (running) begin
      unique case (f_cop)
        flow_pkg::COP_NONE:  cnt_r <= cnt_r;
        flow_pkg::COP_INC:   cnt_r <= cnt_r + CW'(1);
        flow_pkg::COP_DEC:   cnt_r <= cnt_r - CW'(1);
        flow_pkg::COP_RESET: cnt_r <= flow_pkg::CNT_INIT;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start_go) begin
      flag_r <= 2'b00;
    end else if (running && f_fop == 2'b01) begin
      flag_r[f_fsel] <= 1'b1;
    end else if (running && f_fop == 2'b10) begin
      flag_r[f_fsel] <= 1'b0;
    end
  end

  // registered write enable, start wins over stop
  always_ff @(posedge aclk) begin
    if (!aresetn || start_go) begin
      we_r <= 1'b0;
    end else if (running && qual_eff && f_son) begin
      we_r <= 1'b1;
    end else if (running && qual_eff && f_soff) begin
      we_r <= 1'b0;
    end
  end

  // write pointer and segment stepping
  always_ff @(posedge aclk) begin
    if (!aresetn || start_go) begin
      off_r   <= '0;
      seg_r   <= '0;
      sact_r  <= 1'b0;
      spost_r <= '0;
    end else begin
      if (mem_we) begin
        off_r <= ((AW+1)'(off_r) == cur_depth - (AW+1)'(1)) ? '0 : off_r + AW'(1);
      end
      // segment end counts its own post-fill
      if (acq_r == flow_pkg::ACQ_RUN && seg_en && f_segt && !f_trig && !sact_r) begin
        sact_r  <= 1'b1;
        spost_r <= spost_ld;
      end else if (sact_r && (spost_r == '0 || (mem_we && spost_r == (AW+1)'(1)))) begin
        sact_r <= 1'b0;
        seg_r  <= seg_r + SW'(1);
        off_r  <= '0;
      end else if (sact_r && mem_we) begin
        spost_r <= spost_r - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_r  <= flow_pkg::ACQ_IDLE;
      trig_r <= 1'b0;
      post_r <= '0;
      tidx_r <= '0;
      pos_r  <= flow_pkg::POS_PRE;
    end else if (start_go) begin
      acq_r  <= flow_pkg::ACQ_RUN;
      trig_r <= 1'b0;
      pos_r  <= start_pos;
    end else if (running && cmd_stop) begin
      acq_r  <= flow_pkg::ACQ_DONE;
      trig_r <= 1'b1;
    end else if (acq_r == flow_pkg::ACQ_RUN && f_trig) begin
      // a trigger action or a stop command leaves the run phase
      trig_r <= 1'b1;
      post_r <= tpost;
      // trigger index from depth and post-fill
      tidx_r <= cur_depth - tpost;
      acq_r  <= (tpost == '0) ? flow_pkg::ACQ_DONE : flow_pkg::ACQ_POST;
    end else if (acq_r == flow_pkg::ACQ_POST && mem_we) begin
      // finish once post-fill samples are stored
      post_r <= post_r - (AW+1)'(1);
      if (post_r == (AW+1)'(1)) begin
        acq_r <= flow_pkg::ACQ_DONE;
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_goto_follow: assert property (running && f_go && !start_go |=> seq_r == $past(f_go_st))
    else $error("sequencer did not follow goto");
  a_qual_bypass: assert property (!qual_eff |-> mem_we == running)
    else $error("unqualified capture not writing every cycle");
  a_seg_no_store: assert property (running && seg_en && !we_r && !start_go |=> !we_r)
    else $error("storage-on acted in segmented mode");
  a_store_gate: assert property (running && qual_eff && !we_r |-> !mem_we)
    else $error("sample written before storage-on");
  a_post_finish: assert property (acq_r == flow_pkg::ACQ_POST && mem_we
    && post_r == (AW+1)'(1) && !cmd_stop && !start_go |=> acq_r == flow_pkg::ACQ_DONE)
    else $error("capture did not finish after post-fill");
  a_pause_hold: assert property (acq_r == flow_pkg::ACQ_POST && !mem_we && !cmd_stop
    |=> post_r == $past(post_r) && acq_r == flow_pkg::ACQ_POST)
    else $error("paused capture advanced");
  a_stop_forced: assert property (running && cmd_stop && !start_go
    |=> acq_r == flow_pkg::ACQ_DONE && trig_r ##1 acq_r == flow_pkg::ACQ_DONE)
    else $error("stop did not end capture as triggered");
  a_trig_index: assert property (acq_r == flow_pkg::ACQ_RUN && f_trig && !cmd_stop
    && !start_go |=> tidx_r + post_r == $past(cur_depth))
    else $error("trigger index not depth minus post-fill");
  a_cnt_step: assert property (running && !start_go && f_cop == flow_pkg::COP_INC
    |=> cnt_r == $past(cnt_r) + CW'(1))
    else $error("counter increment lost");
  a_flag_set: assert property (running && !start_go && f_fop == 2'b01
    |=> flag_r[$past(f_fsel)])
    else $error("flag not set");

  c_done: cover property (acq_r == flow_pkg::ACQ_POST ##1 acq_r == flow_pkg::ACQ_DONE);
  c_pause: cover property (acq_r == flow_pkg::ACQ_POST && !mem_we);
  c_seg_step: cover property (sact_r ##1 !sact_r);
  c_stop: cover property (running && cmd_stop);
endmodule
`default_nettype wire

// ===== flow_pkg.sv
// shared constants, field layout and helpers for the acquisition controller
package flow_pkg;

  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CMD   = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_PFILL = 8'h0C;
  localparam logic [7:0] A_CNT   = 8'h10;
  localparam logic [7:0] A_TIDX  = 8'h14;
  localparam logic [7:0] A_RADDR = 8'h18;
  localparam logic [7:0] A_RDATA = 8'h1C;
  localparam logic [7:0] A_PROG  = 8'h20;
  localparam logic [7:0] A_LAST  = 8'h2C;

  // control and command fields
  localparam int CTRL_QUAL = 0;
  localparam int CTRL_SEG  = 1;
  localparam int CTRL_PRUN = 2;
  localparam int CTRL_PPWR = 4;
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;

  // status and resource fields
  localparam int S_ACQ   = 0;
  localparam int S_TRIG  = 2;
  localparam int S_PAUSE = 3;
  localparam int S_WE    = 4;
  localparam int S_SEQ   = 5;
  localparam int S_SEGN  = 8;
  localparam int F_CNT   = 0;
  localparam int F_FLAG  = 8;

  // program entry fields, one entry per sequencer state
  localparam int E_SEL  = 0;
  localparam int E_INV  = 4;
  localparam int E_CMP  = 5;
  localparam int E_GOTO = 6;
  localparam int E_GEN  = 8;
  localparam int E_SON  = 9;
  localparam int E_SOFF = 10;
  localparam int E_TRIG = 11;
  localparam int E_SEG  = 12;
  localparam int E_COP  = 13;
  localparam int E_FOP  = 15;
  localparam int E_FSEL = 17;
  localparam int E_UPF  = 18;
  localparam int E_VAL  = 24;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0]  CNT_INIT = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // pre/post split percentages
  localparam int PCT_SMALL = 12;
  localparam int PCT_HALF  = 50;
  localparam int PCT_LARGE = 88;

  typedef enum logic [1:0] {
    POS_PRE    = 2'b00,
    POS_CENTER = 2'b01,
    POS_POST   = 2'b10
  } pos_t;

  typedef enum logic [1:0] {
    COP_NONE  = 2'b00,
    COP_INC   = 2'b01,
    COP_DEC   = 2'b10,
    COP_RESET = 2'b11
  } cop_t;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_RUN  = 2'b01,
    ACQ_POST = 2'b10,
    ACQ_DONE = 2'b11
  } acq_t;

  // post-trigger sample count implied by a split setting
  function automatic logic [15:0] post_default(input logic [1:0] pos, input logic [15:0] depth);
    logic [31:0] p;
    p = 32'(PCT_HALF);
    if (pos == POS_PRE) begin
      p = 32'(PCT_LARGE);
    end else if (pos == POS_POST) begin
      p = 32'(PCT_SMALL);
    end
    return 16'((32'(depth) * p) / 32'd100);
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ===== capture_mem.sv
// sample buffer with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module capture_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock
  input  wire logic          clk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];

  // storage and registered readout
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ===== flow_step.sv
// decodes one sequencer entry against the live probes and counter
`timescale 1ns/1ps
`default_nettype none
module flow_step #(
  parameter int PW = 8,
  parameter int CW = 8
) (
  // entry and operands
  input  wire logic [31:0]   entry,
  input  wire logic [PW-1:0] probe,
  input  wire logic [CW-1:0] count,
  // gated actions
  output logic               go,
  output logic [1:0]         go_st,
  output logic               son,
  output logic               soff,
  output logic               trig,
  output logic               segt,
  output logic [1:0]         cop,
  output logic [1:0]         fop,
  output logic               fsel,
  output logic               upf
);
  logic [15:0] pz;
  logic        hit;

  // condition: a probe bit or a counter compare, optionally inverted
  always_comb begin
    pz  = 16'(probe);
    hit = entry[flow_pkg::E_CMP] ? (count == entry[flow_pkg::E_VAL +: CW])
                                 : pz[entry[flow_pkg::E_SEL +: 4]];
    hit = hit ^ entry[flow_pkg::E_INV];
  end

  // actions fire only on a true condition
  assign go    = hit & entry[flow_pkg::E_GEN];
  assign go_st = entry[flow_pkg::E_GOTO +: 2];
  assign son   = hit & entry[flow_pkg::E_SON];
  assign soff  = hit & entry[flow_pkg::E_SOFF];
  assign trig  = hit & entry[flow_pkg::E_TRIG];
  assign segt  = hit & entry[flow_pkg::E_SEG];
  assign cop   = hit ? entry[flow_pkg::E_COP +: 2] : flow_pkg::COP_NONE;
  assign fop   = hit ? entry[flow_pkg::E_FOP +: 2] : 2'h0;
  assign fsel  = entry[flow_pkg::E_FSEL];
  assign upf   = entry[flow_pkg::E_UPF];
endmodule
`default_nettype wire

// ===== probe_src.sv
// probed-signal source: a pattern that changes on every sample clock
`timescale 1ns/1ps
`default_nettype none
module probe_src #(
  parameter int PW = 8
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // probed signals
  output logic      [PW-1:0] probe
);
  // free-running count, so no sample repeats its neighbour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe <= '0;
    end else begin
      probe <= probe + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the acquisition controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, probe;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          n_errors, n_compared;

  probe_src #(.PW(8)) src (.aclk(aclk), .aresetn(aresetn), .probe(probe));
  acq_control #(.PW(8), .DEPTH(64)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .probe(probe));

  // clock, 20 ns period
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // write: address and data together, bready held until the response
  // ready lines stay high between transfers, so back-to-back calls never toggle them twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("write resp", {30'h0, flow_pkg::RESP_OK}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata; r = rresp;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d & m);
  endtask

  // poll status under a bounded count, then compare
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] s;
    logic [1:0]  r;
    for (int k = 0; k < 100; k++) begin
      rd(flow_pkg::A_STAT, s, r);
      if ((s & m) === v) break;
    end
    chk("status", v, s & m);
  endtask

  // every loaded flow carries a trigger action
  // storage actions are never combined with a segmented buffer
  task automatic run(input logic [31:0] c, input logic [31:0] pf, input logic [31:0] e0,
                     input logic [31:0] e1);
    wr(flow_pkg::A_CTRL, c);
    wr(flow_pkg::A_PFILL, pf);
    wr(flow_pkg::A_PROG, e0);
    wr(flow_pkg::A_PROG + 8'h04, e1);
    wr(flow_pkg::A_CMD, 32'h0000_0001);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rchk("ctrl reset", flow_pkg::A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h30, d, r);
    chk("unmapped resp", {30'h0, flow_pkg::RESP_ERR}, {30'h0, r});
  endtask

  // qualified: storage-on, trigger with post-fill 5, one increment
  task automatic t_qual;
    run(32'h0000_0001, 32'h0000_0005, 32'h0004_2A20, 32'h0000_0000);
    wait_stat(32'h0000_0007, 32'h0000_0007);
    rchk("trig index", flow_pkg::A_TIDX, 32'h0000_00FF, 32'h0000_003B);
    rchk("counter", flow_pkg::A_CNT, 32'h0000_00FF, 32'h0000_0001);
  endtask

  // storage-off ignored when not state-qualified
  task automatic t_unqual;
    run(32'h0000_0000, 32'h0000_0005, 32'h0004_0C20, 32'h0000_0000);
    wait_stat(32'h0000_0007, 32'h0000_0007);
  endtask

  // split settings without post-fill count
  task automatic t_split;
    int pct[3] = '{88, 50, 12};
    for (int p = 0; p < 3; p++) begin
      run(32'(p) << 2, 32'h0000_0000, 32'h0000_0820, 32'h0000_0000);
      wait_stat(32'h0000_0007, 32'h0000_0007);
      rchk("split index", flow_pkg::A_TIDX, 32'h0000_00FF, 32'(64 - (64 * pct[p]) / 100));
    end
    // segmented buffer of four 16-sample segments, pre split
    run(32'h0000_0002, 32'h0000_0000, 32'h0000_0820, 32'h0000_0000);
    wait_stat(32'h0000_0007, 32'h0000_0007);
    rchk("segment index", flow_pkg::A_TIDX, 32'h0000_00FF, 32'(16 - (16 * 88) / 100));
  endtask

  // storage-off after trigger pauses, stop ends as triggered
  task automatic t_pause;
    run(32'h0000_0001, 32'h0000_000F, 32'h0004_0B60, 32'h0000_0420);
    wait_stat(32'h0000_000B, 32'h0000_000A);
    wr(flow_pkg::A_CMD, 32'h0000_0002);
    wait_stat(32'h0000_0007, 32'h0000_0007);
  endtask

  // watchdog
  initial begin
    #(20 * 40000);
    n_errors++;
    print_verdict();
  end

  initial begin
    n_errors = 0; n_compared = 0;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_qual();
    t_unqual();
    t_split();
    t_pause();
    print_verdict();
  end
endmodule
`default_nettype wire
